// >>> dv/aab_dmem_model.sv
// Data-memory model that supplies operand words.
// Assumes the bench drives a word address; read is combinational.
`timescale 1ns/1ps
module aab_dmem_model (
  input wire logic [3:0] addr_i,
  output logic [15:0] rd_data_o
);
  logic [15:0] mem [16];
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem[i] = 16'h8001 ^ (16'(i) * 16'h1357);
    end
    mem[0] = 16'hffff;
    mem[1] = 16'h0000;
  end
  assign rd_data_o = mem[addr_i];
endmodule

// >>> dv/aab_exec_sva.sv
// Port checks for the accumulator datapath.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module aab_exec_sva (
  input logic core_clk_i,
  input logic rst_n_i,
  input logic op_valid_i,
  input aab_pkg::aab_op_t op_i,
  input logic [15:0] dmem_i,
  input logic [7:0] imm_short_i,
  input logic [15:0] pma_i,
  input logic ovm_i,
  input logic [31:0] acc_o,
  input logic [15:0] pc_o,
  input logic done_o,
  input logic jump_o
);
  import aab_pkg::*;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Operation taken with saturation off
  sequence s_op(aab_op_t c);
    op_valid_i && !ovm_i && op_i == c;
  endsequence
  a_done_pulse: assert property (op_valid_i |=> done_o) else $error("done missing");
  a_idle_holds: assert property (!op_valid_i |=> !done_o && $stable(pc_o) && $stable(acc_o))
    else $error("idle cycle changed state");
  a_magnitude_abs: assert property (s_op(AAB_MAGNITUDE) |=>
    acc_o == ($past(acc_o[31]) ? -$past(acc_o) : $past(acc_o))) else $error("magnitude wrong");
  a_short_sum: assert property (s_op(AAB_SUM_SHORT_IMMEDIATE) |=>
    acc_o == $past(acc_o) + {24'h0, $past(imm_short_i)} && !jump_o) else $error("short add wrong");
  a_unsigned_sum: assert property (s_op(AAB_SUM_UNSIGNED) |=>
    acc_o == $past(acc_o) + {16'h0, $past(dmem_i)}) else $error("unsigned add wrong");
  a_upper_low_kept: assert property (s_op(AAB_SUM_UPPER_HALF) |=>
    acc_o[15:0] == $past(acc_o[15:0])) else $error("upper add touched low half");
  a_conj_high_clear: assert property (s_op(AAB_CONJUNCTION_MEM) |=>
    acc_o == {16'h0, $past(acc_o[15:0]) & $past(dmem_i)}) else $error("conjunction wrong");
  a_jump_target: assert property (s_op(AAB_JUMP) |=> pc_o == $past(pma_i) && jump_o)
    else $error("jump target wrong");
  a_jump_via_acc: assert property (s_op(AAB_JUMP_VIA_ACCUMULATOR) |=>
    pc_o == $past(acc_o[15:0]) && jump_o) else $error("indirect jump wrong");
endmodule
bind aab_exec aab_exec_sva u_sva (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .op_valid_i(op_valid_i),
  .op_i(op_i), .dmem_i(dmem_i), .imm_short_i(imm_short_i), .pma_i(pma_i), .ovm_i(ovm_i),
  .acc_o(acc_o), .pc_o(pc_o), .done_o(done_o), .jump_o(jump_o));

// >>> dv/aab_exec_tb.sv
// Self-checking bench: random op stream against a reference model.
// Assumes the checker and data-memory model are compiled first.
`timescale 1ns/1ps
module aab_exec_tb;
  import aab_pkg::*;
  typedef struct packed {
    logic [31:0] acc;
    logic c;
    logic [15:0] pc;
    logic j;
    logic [2:0] s;
    logic v;
    logic [15:0] rd;
  } aab_exp_t;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic vld = 1'b0, sign_extend_mode = 1'b0, ald = 1'b0, we = 1'b0, m_c, carry_o, done_o, jump_o;
  logic ovm = 1'b0, cclr = 1'b0, oclr = 1'b0, upd = 1'b0, m_v, ov_o;
  logic [15:0] stp = 16'h0, rd_o;
  aab_op_t op = AAB_NOP;
  logic [3:0] addr = 4'h0;
  logic [7:0] ims = 8'h0;
  logic [4:0] sh = 5'h0;
  logic [1:0] pm = 2'h0;
  logic [2:0] anx = 3'h0, wsel = 3'h0, rsel = 3'h0, m_sel, sel_o;
  logic [15:0] dmem, iml = 16'h0, pma = 16'h0, treg = 16'h0, wdat = 16'h0, pc_o, m_pc;
  logic [31:0] preg = 32'h0, acc_o, m_acc, seed = 32'h0000000e;
  logic [15:0] m_ar [8];
  int failures = 0;
  int checks = 0;
  aab_exp_t q[$];
  aab_exp_t ex;
  always #10 core_clk_i = ~core_clk_i;
  aab_dmem_model mem_u (.addr_i(addr), .rd_data_o(dmem));
  aab_exec DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .op_valid_i(vld), .op_i(op), .dmem_i(dmem),
    .imm_short_i(ims), .imm_long_i(iml), .pma_i(pma), .shift_i(sh), .treg_i(treg), .preg_i(preg),
    .sign_extend_mode_i(sign_extend_mode), .product_shift_mode_i(pm), .ovm_i(ovm), .ind_update_i(upd),
    .ind_step_i(stp), .arp_load_i(ald), .arp_next_i(anx), .ar_wr_en_i(we), .ar_wr_sel_i(wsel),
    .ar_wr_data_i(wdat), .ar_rd_sel_i(rsel), .carry_clr_i(cclr), .ov_clr_i(oclr), .acc_o(acc_o),
    .carry_o(carry_o), .ov_o(ov_o), .pc_o(pc_o), .index_reg_selector_o(sel_o), .ar_rd_data_o(rd_o),
    .done_o(done_o), .jump_o(jump_o));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [32:0] ext(input logic [15:0] v, input logic [4:0] n, input logic se);
    return {1'b0, {{16{se & v[15]}}, v} << n};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (e !== g) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic add(input logic [32:0] v);
    logic [32:0] s;
    logic o;
    s = {1'b0, m_acc} + v;
    // Signed overflow: like-signed operands, result sign flipped
    o = (m_acc[31] == v[31]) && (s[31] != m_acc[31]);
    m_v = m_v | o;
    m_acc = (o && ovm) ? (m_acc[31] ? 32'h80000000 : 32'h7fffffff) : s[31:0];
    m_c = s[32];
  endtask
  task automatic do_op(input aab_op_t o, input logic free);
    logic [31:0] r, r2, r3;
    logic [15:0] np;
    logic [4:0] n;
    logic c0;
    aab_exp_t e;
    r = rnd();
    r2 = rnd();
    r3 = rnd();
    vld <= 1'b1;
    op <= o;
    addr <= r[3:0];
    ims <= r[11:4];
    sh <= r[16:12];
    sign_extend_mode <= r[17];
    pm <= r[19:18];
    ald <= r[20] & free;
    anx <= r[23:21];
    rsel <= r[26:24];
    iml <= r2[15:0];
    pma <= r2[31:16];
    treg <= r2[31:16] ^ r[15:0];
    preg <= {r2[7:0], r[31:8]};
    ovm <= r3[0] & r3[1];
    cclr <= r3[2] & r3[3];
    oclr <= r3[4] & r3[5];
    upd <= r3[6] & free;
    stp <= r3[31:16];
    @(posedge core_clk_i);
    np = m_pc + 16'h1;
    n = (sh > 5'h10) ? 5'h10 : sh;
    c0 = m_c;
    m_c = m_c & ~cclr;
    m_v = m_v & ~oclr;
    e.j = 1'b0;
    e.rd = m_ar[rsel];
    case (o)
      AAB_MAGNITUDE: begin
        m_v = m_v | (m_acc == 32'h80000000);
        m_acc = (ovm && m_acc == 32'h80000000) ? 32'h7fffffff : (m_acc[31] ? -m_acc : m_acc);
      end
      AAB_SUM_SHIFT: add(ext(dmem, n, sign_extend_mode));
      AAB_SUM_UPPER_HALF: begin
        add({1'b0, dmem, 16'h0});
        m_c = m_c | (c0 & ~cclr);
      end
      AAB_SUM_WITH_CARRY: add({17'h0, dmem} + {32'h0, c0});
      AAB_SUM_UNSIGNED: add({17'h0, dmem});
      AAB_SUM_SHIFT_BY_TREG: add(ext(dmem, {1'b0, treg[3:0]}, sign_extend_mode));
      AAB_SUM_SHORT_IMMEDIATE: add({25'h0, ims});
      AAB_SUM_LONG_IMMEDIATE: begin
        add(ext(iml, {1'b0, sh[3:0]}, sign_extend_mode));
        np = m_pc + 16'h2;
      end
      AAB_INDEX_REG_SUM_IMMEDIATE: m_ar[m_sel] = m_ar[m_sel] + {8'h0, ims};
      AAB_CONJUNCTION_MEM: m_acc = m_acc & {16'h0, dmem};
      AAB_CONJUNCTION_IMMEDIATE: begin
        m_acc = m_acc & ({16'h0, iml} << n);
        np = m_pc + 16'h2;
      end
      AAB_PRODUCT_ACCUMULATE: case (pm)
        2'h0: add({1'b0, preg});
        2'h1: add({1'b0, preg << 1});
        2'h2: add({1'b0, preg << 4});
        default: add({1'b0, $unsigned($signed(preg) >>> 6)});
      endcase
      AAB_JUMP: begin
        e.j = 1'b1;
        np = pma;
        if (upd) m_ar[m_sel] = m_ar[m_sel] + stp;
        if (ald) m_sel = anx;
      end
      AAB_JUMP_VIA_ACCUMULATOR: begin
        e.j = 1'b1;
        np = m_acc[15:0];
      end
      AAB_LOOP_JUMP_NONZERO: begin
        e.j = m_ar[m_sel] != 16'h0;
        m_ar[m_sel] = upd ? m_ar[m_sel] + stp : m_ar[m_sel] - 16'h1;
        np = e.j ? pma : m_pc + 16'h2;
        if (ald) m_sel = anx;
      end
      default: ;
    endcase
    m_pc = np;
    e.acc = m_acc;
    e.c = m_c;
    e.pc = m_pc;
    e.s = m_sel;
    e.v = m_v;
    q.push_back(e);
  endtask
  // Outputs are looked at mid-cycle, where they have settled
  always @(negedge core_clk_i) begin
    if (done_o === 1'b1) begin
      if (q.size() == 0) begin
        failures++;
        $display("mismatch done expected 0 seen 1");
      end else begin
        ex = q.pop_front();
        chk("acc", ex.acc, acc_o);
        chk("carry", {31'h0, ex.c}, {31'h0, carry_o});
        chk("pc", {16'h0, ex.pc}, {16'h0, pc_o});
        chk("jump", {31'h0, ex.j}, {31'h0, jump_o});
        chk("selector", {29'h0, ex.s}, {29'h0, sel_o});
        chk("overflow", {31'h0, ex.v}, {31'h0, ov_o});
        chk("index read", {16'h0, ex.rd}, {16'h0, rd_o});
      end
    end
  end
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    logic [31:0] r;
    repeat (10) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(negedge core_clk_i);
    chk("acc reset", 32'h0, acc_o);
    chk("pc reset", 32'h0, {16'h0, pc_o});
    chk("carry reset", 32'h0, {31'h0, carry_o});
    chk("overflow reset", 32'h0, {31'h0, ov_o});
    {m_acc, m_c, m_v, m_pc, m_sel} = '0;
    @(posedge core_clk_i);
    $display("test reset done");
    for (int k = 7; k >= 0; k--) begin
      r = rnd();
      we <= 1'b1;
      wsel <= 3'(k);
      wdat <= (k == 0) ? 16'h1 : r[15:0];
      @(posedge core_clk_i);
      m_ar[k] = (k == 0) ? 16'h1 : r[15:0];
    end
    we <= 1'b0;
    do_op(AAB_LOOP_JUMP_NONZERO, 1'b0);
    do_op(AAB_LOOP_JUMP_NONZERO, 1'b0);
    $display("test loop boundary done");
    repeat (400) begin
      r = rnd();
      do_op(aab_op_t'(r[3:0]), 1'b1);
    end
    vld <= 1'b0;
    for (int i = 0; i < 20 && q.size() != 0; i++) @(posedge core_clk_i);
    if (q.size() != 0) begin
      failures++;
      $display("mismatch pending expected 0 seen %0d", q.size());
    end
    $display("test random mix done");
    print_verdict();
  end
endmodule

// >>> inc/aab_defines.svh
// Named constants of the accumulator arithmetic and branch datapath.
// Assumes inclusion by bare name from files that need the figures.
`ifndef AAB_DEFINES_SVH
`define AAB_DEFINES_SVH

// Reset values
`define AAB_ACC_RESET 32'h00000000
`define AAB_PC_RESET 16'h0000
`define AAB_AR_RESET 16'h0000
`define AAB_ARP_RESET 3'h0

// Number of index registers
`define AAB_AR_COUNT 8

// Shift limits and field positions
`define AAB_SHIFT_MAX 5'h10
`define AAB_TREG_CNT_MSB 3
`define AAB_LONG_CNT_MSB 3

// Program counter steps for one-word and two-word forms
`define AAB_PC_STEP1 16'h0001
`define AAB_PC_STEP2 16'h0002

// Index register default decrement
`define AAB_AR_DEC 16'h0001

// Saturation limits of the accumulator
`define AAB_SAT_POS 32'h7fffffff
`define AAB_SAT_NEG 32'h80000000

// Product shift mode codes and their shift amounts
`define AAB_PM_NONE 2'h0
`define AAB_PM_LEFT1 2'h1
`define AAB_PM_LEFT4 2'h2
`define AAB_PM_RIGHT6 2'h3
`define AAB_PM_L1_AMT 5'h01
`define AAB_PM_L4_AMT 5'h04
`define AAB_PM_R6_AMT 5'h06

`endif

// >>> inc/aab_pkg.sv
// Types shared by the accumulator arithmetic and branch datapath.
// Assumes the decoder presents one operation code per request.
package aab_pkg;

  typedef enum logic [3:0] {
    AAB_NOP = 4'h0,
    AAB_MAGNITUDE = 4'h1,
    AAB_SUM_SHIFT = 4'h2,
    AAB_SUM_UPPER_HALF = 4'h3,
    AAB_SUM_WITH_CARRY = 4'h4,
    AAB_SUM_UNSIGNED = 4'h5,
    AAB_SUM_SHIFT_BY_TREG = 4'h6,
    AAB_SUM_SHORT_IMMEDIATE = 4'h7,
    AAB_SUM_LONG_IMMEDIATE = 4'h8,
    AAB_INDEX_REG_SUM_IMMEDIATE = 4'h9,
    AAB_CONJUNCTION_MEM = 4'ha,
    AAB_CONJUNCTION_IMMEDIATE = 4'hb,
    AAB_PRODUCT_ACCUMULATE = 4'hc,
    AAB_JUMP = 4'hd,
    AAB_JUMP_VIA_ACCUMULATOR = 4'he,
    AAB_LOOP_JUMP_NONZERO = 4'hf
  } aab_op_t;

endpackage

// >>> inc/aab_shift_if.sv
// Operand shifter connection between the datapath and its shift unit.
// Assumes a purely combinational shift unit on the far side.
`timescale 1ns/1ps
interface aab_shift_if;
  logic [15:0] operand;
  logic [4:0] count;
  logic sign_ext;
  logic [31:0] result;

  modport user (output operand, output count, output sign_ext, input result);
  modport unit (input operand, input count, input sign_ext, output result);
endinterface

// >>> rtl/aab_exec.sv
// Execution datapath for accumulator arithmetic, logic and branches.
// Assumes the decoder holds operands valid in the cycle op_valid_i is high.
//
// Notes on behaviour
// - Negative accumulator becomes its two's complement; with saturation on, 32'h80000000 becomes 32'h7fffffff.
// - Shifted add: zero-fill low, sign-extend by mode.
// - Shift counts 0..16, long immediate and temporary register counts 0..15.
// - Short immediate sum_unsigned_op as unsigned 8-bit value.
// - Upper-half add; lower half kept unless the sum saturates; carry set.
// - Add memory word plus carry bit.
// - Unsigned add zero-extends the memory word.
// - Shift memory word by temporary register count.
// - Temporary-register add sets carry from MSB.
// - Long immediate optionally shifted, then added.
// - Immediate added to selected index register.
// - Memory conjunction clears upper half; constant zero-padded, then shifted.
// - Product accumulate uses product shift mode.
// - Jump loads address, applies index update.
// - Jump target taken from accumulator low half.
// - Loop jump on nonzero index; default decrement.
`timescale 1ns/1ps
`include "aab_defines.svh"
module aab_exec (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic op_valid_i,
  input wire aab_pkg::aab_op_t op_i,
  input wire logic [15:0] dmem_i,
  input wire logic [7:0] imm_short_i,
  input wire logic [15:0] imm_long_i,
  input wire logic [15:0] pma_i,
  input wire logic [4:0] shift_i,
  input wire logic [15:0] treg_i,
  input wire logic [31:0] preg_i,
  input wire logic sign_extend_mode_i,
  input wire logic [1:0] product_shift_mode_i,
  input wire logic ovm_i,
  input wire logic ind_update_i,
  input wire logic [15:0] ind_step_i,
  input wire logic arp_load_i,
  input wire logic [2:0] arp_next_i,
  input wire logic ar_wr_en_i,
  input wire logic [2:0] ar_wr_sel_i,
  input wire logic [15:0] ar_wr_data_i,
  input wire logic [2:0] ar_rd_sel_i,
  input wire logic carry_clr_i,
  input wire logic ov_clr_i,
  output logic [31:0] acc_o,
  output logic carry_o,
  output logic ov_o,
  output logic [15:0] pc_o,
  output logic [2:0] index_reg_selector_o,
  output logic [15:0] ar_rd_data_o,
  output logic done_o,
  output logic jump_o
);
  import aab_pkg::*;

  logic [31:0] acc_reg;
  logic carry_reg;
  logic ov_reg;
  logic [15:0] pc_reg;
  logic [2:0] arp_reg;
  logic [15:0] ar_rd_reg;
  logic done_reg;
  logic jump_reg;
  logic [15:0] ar_mem [`AAB_AR_COUNT];

  logic [31:0] acc_next;
  logic carry_set;
  logic carry_keep;
  logic ovf_evt;
  logic [15:0] pc_next;
  logic jump_next;
  logic ar_upd;
  logic [15:0] ar_new;
  logic [2:0] arp_next;

  logic [31:0] addend;
  logic cin;
  logic [32:0] sum;
  logic add_ovf;
  logic [31:0] add_result;
  logic [31:0] product_shifted;
  logic [15:0] cur_ar;

  aab_shift_if sh ();

  // Counts above the top of the range are held at the top
  function automatic logic [4:0] aab_clamp_shift(input logic [4:0] cnt);
    aab_clamp_shift = (cnt > `AAB_SHIFT_MAX) ? `AAB_SHIFT_MAX : cnt;
  endfunction

  // Saturate on signed overflow when saturation mode is on
  function automatic logic [31:0] aab_limit(input logic [31:0] v, input logic ovf, input logic neg,
                                            input logic sat_on);
    if (ovf && sat_on) begin
      aab_limit = neg ? `AAB_SAT_NEG : `AAB_SAT_POS;
    end else begin
      aab_limit = v;
    end
  endfunction

  aab_shifter u_shifter (
    .sh(sh.unit)
  );

  aab_pshift u_pshift (
    .product_i(preg_i),
    .product_shift_mode_i(product_shift_mode_i),
    .shifted_o(product_shifted)
  );

  assign cur_ar = ar_mem[arp_reg];

  // Operand selection for the shifter and the adder
  always_comb begin
    sh.operand = dmem_i;
    sh.count = 5'h00;
    sh.sign_ext = sign_extend_mode_i;
    addend = 32'h00000000;
    cin = 1'b0;
    case (op_i)
      AAB_SUM_SHIFT: begin
        sh.count = aab_clamp_shift(shift_i);
        addend = sh.result;
      end
      AAB_SUM_UPPER_HALF: begin
        addend = {dmem_i, 16'h0000};
      end
      AAB_SUM_WITH_CARRY: begin
        addend = {16'h0000, dmem_i};
        cin = carry_reg;
      end
      AAB_SUM_UNSIGNED: begin
        sh.sign_ext = 1'b0;
        addend = sh.result;
      end
      AAB_SUM_SHIFT_BY_TREG: begin
        sh.count = {1'b0, treg_i[`AAB_TREG_CNT_MSB:0]};
        addend = sh.result;
      end
      AAB_SUM_SHORT_IMMEDIATE: begin
        addend = {24'h000000, imm_short_i};
      end
      AAB_SUM_LONG_IMMEDIATE: begin
        sh.operand = imm_long_i;
        sh.count = {1'b0, shift_i[`AAB_LONG_CNT_MSB:0]};
        addend = sh.result;
      end
      AAB_CONJUNCTION_IMMEDIATE: begin
        sh.operand = imm_long_i;
        sh.sign_ext = 1'b0;
        sh.count = aab_clamp_shift(shift_i);
      end
      AAB_PRODUCT_ACCUMULATE: begin
        addend = product_shifted;
      end
      default: begin
        addend = 32'h00000000;
      end
    endcase
  end

  // Modulo 2^32 sum with optional saturation
  assign sum = {1'b0, acc_reg} + {1'b0, addend} + {32'h00000000, cin};
  assign add_ovf = (acc_reg[31] == addend[31]) && (sum[31] != acc_reg[31]);
  assign add_result = aab_limit(sum[31:0], add_ovf, acc_reg[31], ovm_i);

  // Result of the operation presented this cycle
  always_comb begin
    acc_next = acc_reg;
    carry_set = 1'b0;
    carry_keep = 1'b1;
    ovf_evt = 1'b0;
    pc_next = pc_reg;
    jump_next = 1'b0;
    ar_upd = 1'b0;
    ar_new = cur_ar;
    arp_next = arp_reg;
    if (op_valid_i) begin
      pc_next = pc_reg + `AAB_PC_STEP1;
      case (op_i)
        AAB_MAGNITUDE: begin
          if (acc_reg[31]) begin
            ovf_evt = (acc_reg == `AAB_SAT_NEG);
            acc_next = aab_limit(32'h00000000 - acc_reg, ovf_evt, 1'b0, ovm_i);
          end
        end
        AAB_SUM_SHIFT, AAB_SUM_WITH_CARRY, AAB_SUM_UNSIGNED, AAB_SUM_SHORT_IMMEDIATE,
        AAB_PRODUCT_ACCUMULATE: begin
          acc_next = add_result;
          carry_set = sum[32];
          carry_keep = 1'b0;
          ovf_evt = add_ovf;
        end
        AAB_SUM_SHIFT_BY_TREG: begin
          acc_next = add_result;
          carry_set = sum[32];
          carry_keep = 1'b0;
          ovf_evt = add_ovf;
        end
        AAB_SUM_LONG_IMMEDIATE: begin
          acc_next = add_result;
          carry_set = sum[32];
          carry_keep = 1'b0;
          ovf_evt = add_ovf;
          pc_next = pc_reg + `AAB_PC_STEP2;
        end
        AAB_SUM_UPPER_HALF: begin
          acc_next = add_result;
          carry_set = sum[32];
          ovf_evt = add_ovf;
        end
        AAB_INDEX_REG_SUM_IMMEDIATE: begin
          ar_upd = 1'b1;
          ar_new = cur_ar + {8'h00, imm_short_i};
        end
        AAB_CONJUNCTION_MEM: begin
          acc_next = {16'h0000, acc_reg[15:0] & dmem_i};
        end
        AAB_CONJUNCTION_IMMEDIATE: begin
          acc_next = acc_reg & sh.result;
          pc_next = pc_reg + `AAB_PC_STEP2;
        end
        AAB_JUMP: begin
          pc_next = pma_i;
          jump_next = 1'b1;
          ar_upd = ind_update_i;
          ar_new = cur_ar + ind_step_i;
          if (arp_load_i) begin
            arp_next = arp_next_i;
          end
        end
        AAB_JUMP_VIA_ACCUMULATOR: begin
          pc_next = acc_reg[15:0];
          jump_next = 1'b1;
        end
        AAB_LOOP_JUMP_NONZERO: begin
          if (cur_ar != 16'h0000) begin
            pc_next = pma_i;
            jump_next = 1'b1;
          end else begin
            pc_next = pc_reg + `AAB_PC_STEP2;
          end
          ar_upd = 1'b1;
          ar_new = ind_update_i ? cur_ar + ind_step_i : cur_ar - `AAB_AR_DEC;
          if (arp_load_i) begin
            arp_next = arp_next_i;
          end
        end
        default: begin
          pc_next = pc_reg + `AAB_PC_STEP1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      acc_reg <= `AAB_ACC_RESET;
    end else begin
      acc_reg <= acc_next;
    end
  end

  // A carry or overflow produced in the clearing cycle wins over the clear
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      carry_reg <= 1'b0;
      ov_reg <= 1'b0;
    end else begin
      carry_reg <= carry_set | (carry_keep & carry_reg & ~carry_clr_i);
      ov_reg <= ovf_evt | (ov_reg & ~ov_clr_i);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pc_reg <= `AAB_PC_RESET;
      jump_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      pc_reg <= pc_next;
      jump_reg <= jump_next;
      done_reg <= op_valid_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      arp_reg <= `AAB_ARP_RESET;
    end else begin
      arp_reg <= arp_next;
    end
  end

  // Index registers; an operation's update wins over a decoder load
  genvar g;
  generate
    for (g = 0; g < `AAB_AR_COUNT; g = g + 1) begin : g_ar
      always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
          ar_mem[g] <= `AAB_AR_RESET;
        end else if (ar_upd && arp_reg == 3'(g)) begin
          ar_mem[g] <= ar_new;
        end else if (ar_wr_en_i && ar_wr_sel_i == 3'(g)) begin
          ar_mem[g] <= ar_wr_data_i;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ar_rd_reg <= `AAB_AR_RESET;
    end else begin
      ar_rd_reg <= ar_mem[ar_rd_sel_i];
    end
  end

  assign acc_o = acc_reg;
  assign carry_o = carry_reg;
  assign ov_o = ov_reg;
  assign pc_o = pc_reg;
  assign index_reg_selector_o = arp_reg;
  assign ar_rd_data_o = ar_rd_reg;
  assign done_o = done_reg;
  assign jump_o = jump_reg;
endmodule

// >>> rtl/aab_pshift.sv
// Product register shifter selected by the product shift mode bits.
// Assumes the mode bits are stable while an accumulate is presented.
`timescale 1ns/1ps
`include "aab_defines.svh"
module aab_pshift (
  input wire logic [31:0] product_i,
  input wire logic [1:0] product_shift_mode_i,
  output logic [31:0] shifted_o
);
  always_comb begin
    case (product_shift_mode_i)
      `AAB_PM_NONE: shifted_o = product_i;
      `AAB_PM_LEFT1: shifted_o = product_i << `AAB_PM_L1_AMT;
      `AAB_PM_LEFT4: shifted_o = product_i << `AAB_PM_L4_AMT;
      `AAB_PM_RIGHT6: shifted_o = $unsigned($signed(product_i) >>> `AAB_PM_R6_AMT);
      default: shifted_o = product_i;
    endcase
  end
endmodule

// >>> rtl/aab_shifter.sv
// Left shifter for 16-bit operands into the 32-bit accumulator field.
// Assumes the caller limits the count to the legal range.
`timescale 1ns/1ps
module aab_shifter (
  aab_shift_if.unit sh
);
  logic [31:0] extended;

  // High bits copy the sign only in sign-extend mode, low bits fill with zero
  assign extended = sh.sign_ext ? {{16{sh.operand[15]}}, sh.operand} : {16'h0000, sh.operand};
  assign sh.result = extended << sh.count;
endmodule
